/* File: cpw_pkg.sv */
package cpw_pkg;

  // Bus widths of the plain register port
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Time base shape: an 8-bit counter extended by two phase bits
  localparam int COUNT_W = 8;
  localparam int EXT_W   = 2;
  localparam int DUTY_W  = COUNT_W + EXT_W;
  localparam int PRE_W   = 6;
  localparam int RES_W   = 4;

  // Oscillator periods per instruction cycle (one timer input clock)
  localparam int OSC_PER_TICK = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_DUTY_H = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_DUTY_L = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_TIMER  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_BUF_H  = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_BUF_L  = 4'h7;

  // Control register fields
  localparam int CTRL_EN     = 0;
  localparam int CTRL_PWM    = 1;
  localparam int CTRL_ALIGN  = 2;
  localparam int CTRL_PRE_LO = 3;
  localparam int CTRL_PRE_HI = 4;
  localparam int CTRL_PST_LO = 5;
  localparam int CTRL_PST_HI = 7;

  // Status register fields
  localparam int STAT_PIN    = 0;
  localparam int STAT_EXT_LO = 1;
  localparam int STAT_EXT_HI = 2;
  localparam int STAT_OVER   = 3;
  localparam int STAT_RES_LO = 4;
  localparam int STAT_RES_HI = 7;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST   = 8'h00;
  localparam logic [DATA_W-1:0] PERIOD_RST = 8'hff;
  localparam logic [DATA_W-1:0] DUTY_RST   = 8'h00;

  // Prescale ratio selection
  typedef enum logic [1:0] {
    CPW_PRE_1  = 2'h0,
    CPW_PRE_4  = 2'h1,
    CPW_PRE_16 = 2'h2,
    CPW_PRE_64 = 2'h3
  } cpw_pre_t;

endpackage

/* File: cpw_tb_if.sv */
`timescale 1ns/100ps
interface cpw_tb_if;
  // Set up by the register side
  logic                          run;
  cpw_pkg::cpw_pre_t             pre_sel;
  logic [cpw_pkg::COUNT_W-1:0]   period_limit;
  // Produced by the time base
  logic [cpw_pkg::COUNT_W-1:0]   timebase_count;
  logic [cpw_pkg::EXT_W-1:0]     ext_bits;
  logic                          rollover;

  modport gen (
    input  run,
    input  pre_sel,
    input  period_limit,
    output timebase_count,
    output ext_bits,
    output rollover
  );

  modport use_tb (
    output run,
    output pre_sel,
    output period_limit,
    input  timebase_count,
    input  ext_bits,
    input  rollover
  );
endinterface

/* File: cpw_timebase.sv */
`timescale 1ns/100ps
module cpw_timebase (
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst,
  // Time base link to the channel
  cpw_tb_if.gen      tb
);

  logic [cpw_pkg::EXT_W-1:0]   phase_r;
  logic [cpw_pkg::PRE_W-1:0]   pre_r;
  logic [cpw_pkg::COUNT_W-1:0] count_r;
  logic [cpw_pkg::PRE_W-1:0]   pre_mask;
  logic                        tick;

  // Prescaler bits that must be full before the timer steps
  always_comb begin
    unique case (tb.pre_sel)
      cpw_pkg::CPW_PRE_1:  pre_mask = 6'h00;
      cpw_pkg::CPW_PRE_4:  pre_mask = 6'h03;
      cpw_pkg::CPW_PRE_16: pre_mask = 6'h0f;
      cpw_pkg::CPW_PRE_64: pre_mask = 6'h3f;
    endcase
  end

  // Timer steps once per four oscillator periods times the prescale ratio
  assign tick = tb.run && (phase_r == 2'h3) && ((pre_r & pre_mask) == pre_mask);

  // Match on the limit clears on the next step; the postscaler is never consulted
  assign tb.rollover = tick && (count_r == tb.period_limit);

  // Oscillator phase inside one instruction cycle
  always_ff @(posedge sys_clk) begin
    if (rst || !tb.run) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Prescaler counts instruction cycles; it restarts with each timer step
  always_ff @(posedge sys_clk) begin
    if (rst || !tb.run) begin
      pre_r <= '0;
    end else if (tick) begin
      pre_r <= '0;
    end else if (phase_r == 2'h3) begin
      pre_r <= pre_r + 6'h01;
    end
  end

  // Period timer; holds its value while stopped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= '0;
    end else if (tb.rollover) begin
      count_r <= '0;
    end else if (tick) begin
      count_r <= count_r + 8'h01;
    end
  end

  // Extension bits: oscillator phase at 1:1, else the top prescaler pair
  always_comb begin
    unique case (tb.pre_sel)
      cpw_pkg::CPW_PRE_1:  tb.ext_bits = phase_r;
      cpw_pkg::CPW_PRE_4:  tb.ext_bits = pre_r[1:0];
      cpw_pkg::CPW_PRE_16: tb.ext_bits = pre_r[3:2];
      cpw_pkg::CPW_PRE_64: tb.ext_bits = pre_r[5:4];
    endcase
  end

  assign tb.timebase_count = count_r;

endmodule

/* File: cpw_pwm_top.sv */
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
// How it works
// - Period is (limit plus one) times four oscillator periods times prescale.
// - Timer matching the limit clears on the next increment, with rollover events.
// - Rollover drives the pin high unless the duty value is zero.
// - Rollover copies the duty register pair into the 10-bit compare buffer.
// - The postscaler never changes the PWM period.
// - Duty is 10 bits over two registers, left or right aligned by select.
// - Duty writes reach the buffer only at the next period match.
// - High time is duty times oscillator period times prescale.
// - Time base is the timer count extended by two low bits.
// - At 1:1 prescale the two low bits are the oscillator phase.
// - Time base equal to buffered duty drives the pin low.
// - Resolution is log2 of four times (limit plus one), up to ten bits.
// - Duty beyond the period never matches; the pin stays as it is.
module cpw_pwm_top #(
  parameter int COUNT_W = cpw_pkg::COUNT_W,
  parameter int DATA_W  = cpw_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // Register port
  input  wire logic [cpw_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]           reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [DATA_W-1:0]           reg_rdata,
  // Output pin to the load
  output logic                             pwm_output_pin
);

  // The time base and register map are built for the documented widths only
  if (COUNT_W != cpw_pkg::COUNT_W) begin : g_bad_count
    $error("cpw_pwm_top: COUNT_W must equal the package timer width");
  end
  if (DATA_W != cpw_pkg::DATA_W) begin : g_bad_data
    $error("cpw_pwm_top: DATA_W must equal the package register width");
  end

  // Registers written by software
  logic [DATA_W-1:0]               ctrl_r;
  logic [DATA_W-1:0]               period_r;
  logic [DATA_W-1:0]               duty_high_reg_r;
  logic [DATA_W-1:0]               duty_low_reg_r;

  // Channel state
  logic [cpw_pkg::DUTY_W-1:0]      buf_r;
  logic [cpw_pkg::DUTY_W-1:0]      buf_nxt;
  logic                            pin_r;
  logic                            pin_nxt;
  logic [DATA_W-1:0]               rdata_r;
  logic [DATA_W-1:0]               rdata_nxt;

  // Decoded control fields
  logic                            chan_en;
  logic                            pwm_mode;
  logic                            duty_align_select;
  logic                            active;

  // Time base view
  logic [cpw_pkg::DUTY_W-1:0]      timebase;
  logic [cpw_pkg::DUTY_W-1:0]      duty_val;
  logic                            duty_zero;
  logic                            match;
  logic                            roll_d_r;

  // Status helpers
  logic [cpw_pkg::DUTY_W:0]        period_len;
  logic                            overrun;
  logic [cpw_pkg::RES_W-1:0]       resolution;

  cpw_tb_if tb_link ();

  cpw_timebase u_timebase (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tb      (tb_link)
  );

  // Control decode
  assign chan_en           = ctrl_r[cpw_pkg::CTRL_EN];
  assign pwm_mode          = ctrl_r[cpw_pkg::CTRL_PWM];
  assign duty_align_select = ctrl_r[cpw_pkg::CTRL_ALIGN];
  assign active            = chan_en && pwm_mode;

  // Timer runs whenever the channel is enabled; the postscale field is not routed
  assign tb_link.run          = chan_en;
  assign tb_link.pre_sel      =
    cpw_pkg::cpw_pre_t'(ctrl_r[cpw_pkg::CTRL_PRE_HI:cpw_pkg::CTRL_PRE_LO]);
  assign tb_link.period_limit = period_r;

  // Ten-bit time base from the timer count and the two extension bits
  assign timebase = {tb_link.timebase_count, tb_link.ext_bits};

  // Duty value gathered from the register pair in the selected alignment
  always_comb begin
    if (duty_align_select) begin
      duty_val = {duty_high_reg_r, duty_low_reg_r[DATA_W-1:DATA_W-2]};
    end else begin
      duty_val = {duty_high_reg_r[1:0], duty_low_reg_r};
    end
  end

  // Zero test on the buffer, which already holds the value of the new period
  assign duty_zero = (buf_r == '0);

  // Compare against the buffer, never against the live registers
  assign match = (timebase == buf_r);

  // Period length in time base steps, for the overrun flag
  assign period_len = {1'b0, period_r, 2'h0} + 11'h004;
  assign overrun    = ({1'b0, buf_r} > period_len);

  // Duty resolution: two bits plus floor log2 of (limit plus one)
  always_comb begin
    logic [COUNT_W:0] span;
    span       = {1'b0, period_r} + 9'h001;
    resolution = 4'h2;
    for (int i = 1; i <= COUNT_W; i++) begin
      if (span >= (9'h001 << i)) begin
        resolution = 4'(i + 2);
      end
    end
  end

  // Control register; the instruction-clock choice is implicit in this timer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= cpw_pkg::CTRL_RST;
    end else if (reg_wr && (reg_addr == cpw_pkg::OFF_CTRL)) begin
      ctrl_r <= reg_wdata;
    end
  end

  // Period limit; a change takes effect at the next compare against the timer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      period_r <= cpw_pkg::PERIOD_RST;
    end else if (reg_wr && (reg_addr == cpw_pkg::OFF_PERIOD)) begin
      period_r <= reg_wdata;
    end
  end

  // Duty register pair; writable at any time because the buffer shields the pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      duty_high_reg_r <= cpw_pkg::DUTY_RST;
      duty_low_reg_r  <= cpw_pkg::DUTY_RST;
    end else if (reg_wr) begin
      if (reg_addr == cpw_pkg::OFF_DUTY_H) begin
        duty_high_reg_r <= reg_wdata;
      end
      if (reg_addr == cpw_pkg::OFF_DUTY_L) begin
        duty_low_reg_r <= reg_wdata;
      end
    end
  end

  // Compare buffer loads only on rollover, and only while in PWM mode
  always_comb begin
    buf_nxt = buf_r;
    if (active && tb_link.rollover) begin
      buf_nxt = duty_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_r <= '0;
    end else begin
      buf_r <= buf_nxt;
    end
  end

  // A match is acted on one edge after the time base reaches the buffer, so the
  // set trails rollover by one edge too; the high time is then exactly duty steps
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      roll_d_r <= 1'b0;
    end else begin
      roll_d_r <= active && tb_link.rollover;
    end
  end

  // Pin: low while not active, set just after rollover, a match clears it, otherwise it keeps its level
  always_comb begin
    pin_nxt = pin_r;
    if (!active) begin
      pin_nxt = 1'b0;
    end else if (roll_d_r && !duty_zero) begin
      pin_nxt = 1'b1;
    end else if (match) begin
      pin_nxt = 1'b0;
    end
  end

  // Pin flop; a zero buffer leaves the set out and lets the match hold it low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign pwm_output_pin = pin_r;

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rdata_nxt = '0;
    unique case (reg_addr)
      cpw_pkg::OFF_CTRL:   rdata_nxt = ctrl_r;
      cpw_pkg::OFF_PERIOD: rdata_nxt = period_r;
      cpw_pkg::OFF_DUTY_H: rdata_nxt = duty_high_reg_r;
      cpw_pkg::OFF_DUTY_L: rdata_nxt = duty_low_reg_r;
      cpw_pkg::OFF_TIMER:  rdata_nxt = tb_link.timebase_count;
      cpw_pkg::OFF_STATUS: begin
        rdata_nxt[cpw_pkg::STAT_PIN]                             = pin_r;
        rdata_nxt[cpw_pkg::STAT_EXT_HI:cpw_pkg::STAT_EXT_LO]     = tb_link.ext_bits;
        rdata_nxt[cpw_pkg::STAT_OVER]                            = overrun;
        rdata_nxt[cpw_pkg::STAT_RES_HI:cpw_pkg::STAT_RES_LO]     = resolution;
      end
      cpw_pkg::OFF_BUF_H:  rdata_nxt = {6'h00, buf_r[cpw_pkg::DUTY_W-1:DATA_W]};
      cpw_pkg::OFF_BUF_L:  rdata_nxt = buf_r[DATA_W-1:0];
      default:             rdata_nxt = '0;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

/* File: cpw_load.sv */
`timescale 1ns/100ps
module cpw_load (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Pin from the channel
  input  wire logic        pwm_output_pin,
  // Last pulse width, last period, rising edge count
  output logic      [19:0] hi_w,
  output logic      [19:0] per_w,
  output logic      [15:0] rises
);
  logic        last_r;
  logic [19:0] hi_r;
  logic [19:0] gap_r;

  // Passive load: only measures, so it can never mask a pin fault
  always_ff @(posedge sys_clk) begin
    last_r <= rst ? 1'b0 : pwm_output_pin;
    hi_r <= pwm_output_pin ? hi_r + 20'h1 : 20'h0;
    gap_r <= (pwm_output_pin && !last_r) ? 20'h1 : gap_r + 20'h1;
    if (rst) rises <= 16'h0;
    else if (pwm_output_pin && !last_r) rises <= rises + 16'h1;
    if (pwm_output_pin && !last_r) per_w <= gap_r;
    if (!pwm_output_pin && last_r) hi_w <= hi_r;
  end
endmodule

/* File: cpw_pwm_chk.sv */
`timescale 1ns/100ps
module cpw_pwm_chk #(
  parameter int COUNT_W = 8,
  parameter int DATA_W  = 8
) (
  // Clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst,
  // Register port
  input wire logic [cpw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0]          reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [DATA_W-1:0]          reg_rdata,
  // Pin
  input wire logic                       pwm_output_pin
);
  logic [7:0]  ctl_r, per_r, dh_r, dl_r;
  logic [19:0] quiet_r, gap_r, hi_r, pre, plen;
  logic [9:0]  duty;
  logic        on;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Settings seen by the time base
  assign duty = ctl_r[2] ? {dh_r, dl_r[7:6]} : {dh_r[1:0], dl_r};
  assign pre  = 20'h1 << {ctl_r[4:3], 1'b0};
  assign plen = (20'(per_r) + 20'h1) * 20'h4 * pre;
  assign on   = ctl_r[1:0] == 2'h3;

  // Shadow registers; quiet counts cycles since any write, so that
  // checks wait until a rollover has taken in the current settings
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_r <= cpw_pkg::CTRL_RST;
      per_r <= cpw_pkg::PERIOD_RST;
      dh_r <= cpw_pkg::DUTY_RST;
      dl_r <= cpw_pkg::DUTY_RST;
    end else if (reg_wr) begin
      if (reg_addr == cpw_pkg::OFF_CTRL) ctl_r <= reg_wdata;
      if (reg_addr == cpw_pkg::OFF_PERIOD) per_r <= reg_wdata;
      if (reg_addr == cpw_pkg::OFF_DUTY_H) dh_r <= reg_wdata;
      if (reg_addr == cpw_pkg::OFF_DUTY_L) dl_r <= reg_wdata;
    end
  end

  // Cycle counters for quiet time, period and high time
  always_ff @(posedge sys_clk) begin
    if (rst || reg_wr) quiet_r <= 20'h0;
    else if (quiet_r != 20'hfffff) quiet_r <= quiet_r + 20'h1;
    gap_r <= (rst || $rose(pwm_output_pin)) ? 20'h1 : gap_r + 20'h1;
    hi_r <= pwm_output_pin ? hi_r + 20'h1 : 20'h0;
  end

  sequence s_ctl_wr;
    reg_wr && reg_addr == cpw_pkg::OFF_CTRL;
  endsequence
  sequence s_ctl_rd;
    reg_rd && reg_addr == cpw_pkg::OFF_CTRL;
  endsequence

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (s_ctl_wr ##1 s_ctl_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control readback wrong");
  a_off_pin_low: assert property (
    s_ctl_wr and reg_wdata[1:0] != 2'h3 |-> ##2 !pwm_output_pin)
    else $error("pin not low when channel off");
  a_rise_when_on: assert property ($rose(pwm_output_pin) |-> on)
    else $error("pin rose while channel off");
  a_period_len: assert property (
    $rose(pwm_output_pin) && quiet_r > gap_r + 20'h2 |-> gap_r == plen)
    else $error("period length wrong");
  a_high_width: assert property (
    $fell(pwm_output_pin) && on && quiet_r > hi_r + 20'h2 |-> hi_r == 20'(duty) * pre)
    else $error("high time wrong");
  a_zero_duty: assert property (
    on && duty == 10'h0 && quiet_r > 2 * plen + 2 |-> !pwm_output_pin)
    else $error("pin set with zero duty");
  a_over_high: assert property (
    on && 20'(duty) * pre >= plen && quiet_r > 2 * plen + 2 |-> pwm_output_pin)
    else $error("pin cleared with duty beyond period");
endmodule

bind cpw_pwm_top cpw_pwm_chk #(.COUNT_W(COUNT_W), .DATA_W(DATA_W)) u_cpw_pwm_chk (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pwm_output_pin(pwm_output_pin));

/* File: cpw_pwm_top_tb.sv */
`timescale 1ns/100ps
module cpw_pwm_top_tb;
  logic sys_clk, rst, reg_wr, reg_rd, pwm_output_pin, al;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, q, per, cv;
  logic [9:0]  d;
  logic [1:0]  sel;
  logic [19:0] hi_w, per_w;
  logic [15:0] rises;
  int          err_count, checks, k, r;

  cpw_pwm_top u_cpw_pwm_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm_output_pin(pwm_output_pin));
  cpw_load u_cpw_load (.sys_clk(sys_clk), .rst(rst), .pwm_output_pin(pwm_output_pin),
    .hi_w(hi_w), .per_w(per_w), .rises(rises));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: register %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_wave(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: waveform %0d, expected %0d", $time, got, exp);
    end
  endtask

  // Strobes are raised right after an edge and held through one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic duty(input logic [9:0] v, input logic a);
    wr(cpw_pkg::OFF_DUTY_H, a ? v[9:2] : {6'h0, v[9:8]});
    wr(cpw_pkg::OFF_DUTY_L, a ? {v[1:0], 6'h0} : v[7:0]);
  endtask

  // Idle the bus and wait for n new pulses, bounded
  task automatic wait_rise(input int n);
    logic [15:0] r0;
    int i;
    r0 = rises;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    for (i = 0; i < 30000 && 16'(rises - r0) < n; i++) @(posedge sys_clk);
    if (16'(rises - r0) < n) begin
      err_count++;
      $display("Error %0t: pulse missing", $time);
      conclude();
    end
  endtask

  function automatic logic [19:0] plen(input logic [7:0] p, input logic [1:0] s);
    return ((20'(p) + 20'h1) * 20'h4) << {s, 1'b0};
  endfunction

  // Resolution in bits: floor of log2 of the time base length
  function automatic logic [7:0] res_bits(input logic [7:0] p);
    return 8'($clog2(4 * (int'(p) + 1) + 1) - 1);
  endfunction

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_count = 0;
    checks = 0;
    r = $urandom(52);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, then an unmapped read
    rd(cpw_pkg::OFF_CTRL, q); chk_reg(q, cpw_pkg::CTRL_RST);
    rd(cpw_pkg::OFF_PERIOD, q); chk_reg(q, cpw_pkg::PERIOD_RST);
    rd(cpw_pkg::OFF_DUTY_L, q); chk_reg(q, cpw_pkg::DUTY_RST);
    rd(4'h9, q); chk_reg(q, 8'h00);
    $display("test reset done");
    // Every prescale, growing periods so the timer never wraps; last is full resolution
    for (k = 0; k < 9; k++) begin
      sel = (k == 8) ? 2'h0 : 2'(k);
      per = (k == 8) ? 8'hff : 8'(k * 4 + $urandom_range(3));
      d = (k == 8) ? 10'h3ff : (k == 0) ? 10'h1 : 10'($urandom_range(4 * per + 3, 1));
      al = 1'($urandom);
      cv = {3'($urandom), sel, al, 2'h3};
      wr(cpw_pkg::OFF_PERIOD, per);
      duty(d, al);
      wr(cpw_pkg::OFF_CTRL, cv);
      rd(cpw_pkg::OFF_CTRL, q); chk_reg(q, cv);
      rd(cpw_pkg::OFF_STATUS, q);
      chk_reg({4'h0, q[7:4]}, res_bits(per));
      wait_rise(3);
      chk_wave(per_w, plen(per, sel));
      chk_wave(hi_w, 20'(d) << {sel, 1'b0});
      $display("test config %0d done", k);
    end
    // New duty written mid-pulse only applies from the next period
    wait_rise(1);
    duty(10'h010, al);
    wait_rise(1); chk_wave(hi_w, 20'h3ff);
    wait_rise(1); chk_wave(hi_w, 20'h010);
    rd(cpw_pkg::OFF_BUF_L, q); chk_reg(q, 8'h10);
    rd(cpw_pkg::OFF_BUF_H, q); chk_reg(q, 8'h00);
    $display("test reload done");
    duty(10'h0, al);
    reg_wr <= 1'b0;
    repeat (2200) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_wave(20'(pwm_output_pin), 20'h0);
    @(posedge sys_clk);
    wr(cpw_pkg::OFF_PERIOD, 8'h7f);
    duty(10'h3ff, al);
    reg_wr <= 1'b0;
    repeat (2200) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_wave(20'(pwm_output_pin), 20'h1);
    @(posedge sys_clk);
    rd(cpw_pkg::OFF_STATUS, q); chk_reg({7'h0, q[3]}, 8'h01);
    wr(cpw_pkg::OFF_CTRL, 8'h01);
    reg_wr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_wave(20'(pwm_output_pin), 20'h0);
    $display("test edge duty done");
    conclude();
  end
endmodule
